// ===== core/aalo_pkg.sv
/*
  aalo_pkg: shared constants and the operation enumeration for the
  add and logic datapath slice.
  assumes: included before any aalo module; nothing is imported.
*/
package aalo_pkg;

  localparam int unsigned DATA_W   = 8;
  localparam int unsigned NIB_W    = 4;

  localparam logic [7:0] WREG_RST  = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic       FLAG_RST  = 1'b0;

  localparam int unsigned OP_CYCLES = 1;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_ADD_MEM,
    OP_AND_ACC,
    OP_AND_IMM,
    OP_AND_MEM
  } aalo_op_t;

endpackage

// ===== core/aalo_alu.sv
/*
  aalo_alu: combinational result and flag compute for the add and
  the three bitwise AND forms.
  assumes: operands are stable in the cycle the operation is issued.
*/
`timescale 1ns/1ns
module aalo_alu (
  // operands
  input  wire logic [7:0] opA,
  input  wire logic [7:0] opB,
  input  wire logic       doAdd,
  // results
  output logic      [7:0] result,
  output logic            zeroOut,
  output logic            carryOut,
  output logic            halfCarryOut,
  output logic            overflowOut
);

  logic [8:0] sum;
  logic [4:0] lowSum;

  always_comb begin
    sum          = {1'b0, opA} + {1'b0, opB};
    lowSum       = {1'b0, opA[3:0]} + {1'b0, opB[3:0]};
    if (doAdd) begin
      result     = sum[7:0];
    end else begin
      result     = opA & opB;
    end
    zeroOut      = (result == aalo_pkg::ZERO_BYTE);
    carryOut     = sum[8];
    halfCarryOut = lowSum[4];
    // signed overflow: same operand signs, different result sign
    overflowOut  = (opA[7] == opB[7]) && (sum[7] != opA[7]);
  end

endmodule

// ===== core/aalo_core.sv
/*
  aalo_core: execute slice for add-to-memory and the three AND forms.
  holds the working register and the status flags; memory write-back
  is a one-cycle strobe with data.
  assumes: the decoder issues one operation per cycle with the addressed
  memory byte already read onto memRdData; addressing is outside.
  there is no forwarding here: when the next operation reads the byte
  just written, the memory side must hand memWrData back on memRdData.
  operation codes past the last named one behave as an idle cycle,
  apart from an external working register load.
*/
`timescale 1ns/1ns

// Behaviour
// - add to memory writes working register plus memory byte back and updates overflow, zero, half-carry and carry.
// - AND with memory puts working register AND memory byte into the working register.
// - AND with memory changes only the zero flag.
// - AND with immediate puts working register AND immediate into the working register.
// - AND with immediate changes only the zero flag, set when the result is all zeros.
// - AND to memory writes memory byte AND working register back to memory, working register untouched.
module aalo_core (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rstn,
  // operation issue
  input  wire aalo_pkg::aalo_op_t opIn,
  input  wire logic        [7:0] immData,
  input  wire logic        [7:0] memRdData,
  // working register load from other instructions
  input  wire logic              wregLoad,
  input  wire logic        [7:0] wregLoadData,
  // memory write-back
  output logic                   memWrEn,
  output logic             [7:0] memWrData,
  // architectural state
  output logic             [7:0] workingRegister,
  output logic                   zeroFlag,
  output logic                   carryFlag,
  output logic                   halfCarryFlag,
  output logic                   overflowFlag,
  output logic                   opDone
);

  logic [7:0] wreg_ff;
  logic       zero_ff;
  logic       carry_ff;
  logic       halfCarry_ff;
  logic       overflow_ff;
  logic       memWrEn_ff;
  logic [7:0] memWrData_ff;
  logic       done_ff;

  logic [7:0] operandB;
  logic       isAdd;
  logic [7:0] aluResult;
  logic       aluZero;
  logic       aluCarry;
  logic       aluHalf;
  logic       aluOver;

  // op writes its result back to the addressed byte
  function automatic logic writesMem(input aalo_pkg::aalo_op_t op);
    writesMem = (op == aalo_pkg::OP_ADD_MEM) || (op == aalo_pkg::OP_AND_MEM);
  endfunction

  // op owns the working register this cycle, so a load in that cycle is dropped
  function automatic logic ownsWreg(input aalo_pkg::aalo_op_t op);
    ownsWreg = (op == aalo_pkg::OP_AND_ACC) || (op == aalo_pkg::OP_AND_IMM);
  endfunction

  // op moves the arithmetic flags; only the add does
  function automatic logic movesArith(input aalo_pkg::aalo_op_t op);
    movesArith = (op == aalo_pkg::OP_ADD_MEM);
  endfunction

  // op produces a byte result whose zero test is kept
  function automatic logic movesZero(input aalo_pkg::aalo_op_t op);
    movesZero = writesMem(op) || ownsWreg(op);
  endfunction

  // only the immediate form takes its second operand from the instruction
  always_comb begin
    isAdd = (opIn == aalo_pkg::OP_ADD_MEM);
    if (opIn == aalo_pkg::OP_AND_IMM) begin
      operandB = immData;
    end else begin
      operandB = memRdData;
    end
  end

  aalo_alu u_alu (
    .opA          (wreg_ff),
    .opB          (operandB),
    .doAdd        (isAdd),
    .result       (aluResult),
    .zeroOut      (aluZero),
    .carryOut     (aluCarry),
    .halfCarryOut (aluHalf),
    .overflowOut  (aluOver)
  );

  // working register; an issued AND-with-memory or AND-with-immediate takes priority over an external load
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wreg_ff <= aalo_pkg::WREG_RST;
    end else begin
      case (opIn)
        aalo_pkg::OP_AND_ACC: begin
          wreg_ff <= aluResult;
        end
        aalo_pkg::OP_AND_IMM: begin
          wreg_ff <= aluResult;
        end
        default: begin
          // the AND-to-memory form leaves the register alone
          if (wregLoad && !ownsWreg(opIn)) begin
            wreg_ff <= wregLoadData;
          end else begin
            wreg_ff <= wreg_ff;
          end
        end
      endcase
    end
  end

  // zero flag follows every form handled here
  always_ff @(posedge clock) begin
    if (!rstn) begin
      zero_ff <= aalo_pkg::FLAG_RST;
    end else begin
      case (opIn)
        aalo_pkg::OP_ADD_MEM: begin
          zero_ff <= aluZero;
        end
        aalo_pkg::OP_AND_ACC: begin
          zero_ff <= aluZero;
        end
        aalo_pkg::OP_AND_IMM: begin
          zero_ff <= aluZero;
        end
        aalo_pkg::OP_AND_MEM: begin
          zero_ff <= aluZero;
        end
        default: begin
          zero_ff <= zero_ff;
        end
      endcase
    end
  end

  // arithmetic flags move only on the add; AND forms hold them
  always_ff @(posedge clock) begin
    if (!rstn) begin
      carry_ff <= aalo_pkg::FLAG_RST;
    end else if (movesArith(opIn)) begin
      carry_ff <= aluCarry;
    end else begin
      carry_ff <= carry_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      halfCarry_ff <= aalo_pkg::FLAG_RST;
    end else if (movesArith(opIn)) begin
      halfCarry_ff <= aluHalf;
    end else begin
      halfCarry_ff <= halfCarry_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      overflow_ff <= aalo_pkg::FLAG_RST;
    end else if (movesArith(opIn)) begin
      overflow_ff <= aluOver;
    end else begin
      overflow_ff <= overflow_ff;
    end
  end

  // memory write-back strobe, one cycle after issue
  always_ff @(posedge clock) begin
    if (!rstn) begin
      memWrEn_ff <= 1'b0;
    end else begin
      memWrEn_ff <= writesMem(opIn);
    end
  end

  // write data holds between writes so the memory side may sample late
  always_ff @(posedge clock) begin
    if (!rstn) begin
      memWrData_ff <= aalo_pkg::ZERO_BYTE;
    end else if (writesMem(opIn)) begin
      memWrData_ff <= aluResult;
    end else begin
      memWrData_ff <= memWrData_ff;
    end
  end

  // every form completes in a single cycle, so done is a plain echo of issue
  always_ff @(posedge clock) begin
    if (!rstn) begin
      done_ff <= 1'b0;
    end else begin
      // unnamed codes are idle, so done tracks the named forms only
      done_ff <= movesZero(opIn);
    end
  end

  assign memWrEn         = memWrEn_ff;
  assign memWrData       = memWrData_ff;
  assign workingRegister = wreg_ff;
  assign zeroFlag        = zero_ff;
  assign carryFlag       = carry_ff;
  assign halfCarryFlag   = halfCarry_ff;
  assign overflowFlag    = overflow_ff;
  assign opDone          = done_ff;

endmodule

// ===== tb/aalo_core_checker.sv
/* aalo_chk: port assertions for aalo_core.
   assumes: one clock domain; bound to every aalo_core below. */
`timescale 1ns/1ns
module aalo_chk (
  // watched core ports
  input wire logic               clock,
  input wire logic               rstn,
  input wire aalo_pkg::aalo_op_t opIn,
  input wire logic [7:0]         immData,
  input wire logic [7:0]         memRdData,
  input wire logic               wregLoad,
  input wire logic               memWrEn,
  input wire logic [7:0]         memWrData,
  input wire logic [7:0]         workingRegister,
  input wire logic               zeroFlag,
  input wire logic               carryFlag,
  input wire logic               halfCarryFlag,
  input wire logic               overflowFlag,
  input wire logic               opDone
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire [8:0] sum  = {1'b0, workingRegister} + memRdData;
  wire [7:0] bitwise_and_to_memory_op = workingRegister & memRdData;
  wire [7:0] andI = workingRegister & immData;
  AST_ADD: assert property (opIn == aalo_pkg::OP_ADD_MEM |=>
    memWrEn && {carryFlag, memWrData} == $past(sum)) else $error("add write wrong");
  AST_ANDACC: assert property (opIn == aalo_pkg::OP_AND_ACC |=>
    workingRegister == $past(bitwise_and_to_memory_op)) else $error("and acc wrong");
  AST_ANDKEEP: assert property (opIn == aalo_pkg::OP_AND_ACC |=>
    $stable(carryFlag) && $stable(halfCarryFlag) && $stable(overflowFlag)) else $error("flags moved");
  AST_IMM: assert property (opIn == aalo_pkg::OP_AND_IMM |=>
    workingRegister == $past(andI)) else $error("and imm wrong");
  AST_IMMZ: assert property (opIn == aalo_pkg::OP_AND_IMM |=>
    zeroFlag == (workingRegister == 8'h00) && $stable(carryFlag)) else $error("imm zero wrong");
  AST_MEM: assert property (opIn == aalo_pkg::OP_AND_MEM && !wregLoad |=>
    memWrEn && memWrData == $past(bitwise_and_to_memory_op) && $stable(workingRegister)) else $error("and mem wrong");
  AST_MEMONE: assert property (opIn == aalo_pkg::OP_AND_MEM |=>
    opDone && zeroFlag == (memWrData == 8'h00) && $stable(overflowFlag)) else $error("mem flags wrong");
endmodule

bind aalo_core aalo_chk aalo_chk_i (.*);

// ===== tb/add_and_logic_ops_tb_top.sv
/* add_and_logic_ops_tb_top: random ops checked against a reference model.
   assumes: aalo_pkg, aalo_core and the checker are compiled first. */
`timescale 1ns/1ns
module add_and_logic_ops_tb_top;
  logic               clock, rstn, wregLoad, memWrEn, opDone;
  logic               zeroFlag, carryFlag, halfCarryFlag, overflowFlag;
  logic [7:0]         immData, memRdData, wregLoadData, memWrData, workingRegister;
  aalo_pkg::aalo_op_t opIn;
  logic [7:0]         eW, eD;
  logic               eZ, eC, eA, eV, eE, eN;
  int                 fails, cmp_count, s;
  aalo_core aalo_core_i (.*);
  always #4 clock = ~clock;
  // model updates at the same edge as the core, so compares wait half a cycle
  always @(posedge clock) begin
    if (!rstn) begin
      {eW, eD, eZ, eC, eA, eV, eE, eN} = '0;
    end else begin
      s = eW + memRdData;
      eE = opIn inside {aalo_pkg::OP_ADD_MEM, aalo_pkg::OP_AND_MEM};
      case (opIn)
        aalo_pkg::OP_ADD_MEM: begin
          eD = 8'(s);
          eC = s[8];
          eA = (eW[3:0] + memRdData[3:0]) > 15;
          eV = (eW[7] == memRdData[7]) && (eD[7] != eW[7]);
          eZ = eD == 8'h00;
        end
        aalo_pkg::OP_AND_ACC: eW = eW & memRdData;
        aalo_pkg::OP_AND_IMM: eW = eW & immData;
        aalo_pkg::OP_AND_MEM: eD = eW & memRdData;
        default: ;
      endcase
      if (opIn inside {aalo_pkg::OP_AND_ACC, aalo_pkg::OP_AND_IMM}) eZ = eW == 8'h00;
      if (opIn == aalo_pkg::OP_AND_MEM) eZ = eD == 8'h00;
      if (wregLoad && !(opIn inside {aalo_pkg::OP_AND_ACC, aalo_pkg::OP_AND_IMM})) eW = wregLoadData;
      eN = opIn != aalo_pkg::OP_NONE;
    end
  end
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t byte %h want %h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t bit %b want %b", $time, g, e);
    end
  endtask
  task automatic check;
    cmp8(workingRegister, eW);
    cmp8(memWrData, eD);
    cmp1(zeroFlag, eZ);
    cmp1(carryFlag, eC);
    cmp1(halfCarryFlag, eA);
    cmp1(overflowFlag, eV);
    cmp1(memWrEn, eE);
    cmp1(opDone, eN);
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    report_and_stop;
  end
  initial begin
    {clock, rstn, wregLoad, immData, memRdData, wregLoadData} = '0;
    opIn = aalo_pkg::OP_NONE;
    void'($urandom(32'h058E));
    repeat (6) @(posedge clock);
    @(negedge clock);
    check;
    @(posedge clock);
    rstn <= 1'b1;
    repeat (300) begin
      @(posedge clock);
      opIn <= aalo_pkg::aalo_op_t'(3'($urandom_range(4, 0)));
      immData <= 8'($urandom);
      memRdData <= 8'($urandom);
      wregLoad <= $urandom_range(3, 0) == 0;
      wregLoadData <= 8'($urandom);
      @(negedge clock);
      check;
    end
    report_and_stop;
  end
endmodule
